// File: inc/fcsc_regs.vh
// constants for the flash command host controller
`ifndef FCSC_REGS_VH
`define FCSC_REGS_VH
// =====================================================
// command codes and unlock addresses
`define FCSC_UNLOCK_ADDR1 21'h000555
`define FCSC_UNLOCK_ADDR2 21'h0002AA
`define FCSC_UNLOCK_DATA1 16'h00AA
`define FCSC_UNLOCK_DATA2 16'h0055
`define FCSC_CMD_RESET 16'h00F0
`define FCSC_CMD_AUTOSEL 16'h0090
`define FCSC_CMD_ENTER 16'h0088
`define FCSC_CMD_EXIT1 16'h0090
`define FCSC_CMD_EXIT2 16'h0000
// =====================================================
// serial id locations
`define FCSC_ID_BOTTOM 21'h000000
`define FCSC_ID_TOP 21'h1F8000
`define FCSC_ID_WORDS 4'h8
// =====================================================
// strobe timing in ns and derived cycles at 10 MHz
`define FCSC_CLK_NS 100
`define FCSC_TSETUP_NS 100
`define FCSC_TSETUP_CYC ((`FCSC_TSETUP_NS + `FCSC_CLK_NS - 1) / `FCSC_CLK_NS)
`define FCSC_TPULSE_NS 200
`define FCSC_TPULSE_CYC ((`FCSC_TPULSE_NS + `FCSC_CLK_NS - 1) / `FCSC_CLK_NS)
`define FCSC_TACC_NS 200
`define FCSC_TACC_CYC ((`FCSC_TACC_NS + `FCSC_CLK_NS - 1) / `FCSC_CLK_NS)
`endif

// File: verilog/fcsc_host.v
// host controller that drives flash command sequences over the strobes
`timescale 1ns/1ps
`default_nettype none
`include "fcsc_regs.vh"
module fcsc_host #(
  parameter AW = 21,
  parameter DW = 16
) (
  input wire clk,
  input wire rst_n,
  input wire reqValid, // one-cycle request pulse
  input wire [2:0] reqOp, // operation code
  input wire [AW-1:0] reqAddr, // user word address
  input wire [DW-1:0] reqData, // user write data
  input wire bottomBoot, // part is bottom boot
  input wire lockoutActive, // supply below supply_lockout_threshold
  input wire [DW-1:0] flashDqIn, // data pins, input side
  output reg reqReady, // idle and able to take a request
  output reg respValid, // one-cycle completion pulse
  output reg [DW-1:0] respData, // read data
  output reg inSecured, // host believes secured mode active
  output reg inAutoselect, // host believes autoselect active
  output reg [AW-1:0] flashAddr, // address pins
  output reg [DW-1:0] flashDqOut, // data pins, output side
  output reg flashDqOe, // high while driving data pins
  output reg flashCe_n, // flash select, active low
  output reg flashWe_n, // write strobe, active low
  output reg flashOe_n, // output enable, active low
  output reg flashReset_n // hardware reset pin, active low
);
  // =====================================================
  // operation codes
  localparam OP_READ = 3'h0;
  localparam OP_WRITE = 3'h1; // raw single write cycle
  localparam OP_RESET = 3'h2;
  localparam OP_AUTOSEL = 3'h3;
  localparam OP_ENTER = 3'h4;
  localparam OP_EXIT = 3'h5;
  localparam OP_READID = 3'h6; // reads serial id word reqAddr[2:0]
  localparam OP_HWRESET = 3'h7;
  // =====================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_RISE = 3'h3;
  localparam S_RDWAIT = 3'h4;
  localparam S_HWRST = 3'h5;
  localparam S_DONE = 3'h6;
  reg [2:0] state; // sequencer state
  reg [2:0] op; // latched operation
  reg [2:0] step; // cycle index inside a sequence
  reg [2:0] nSteps; // number of write cycles in sequence
  reg [3:0] cnt; // timing counter
  reg [AW-1:0] uAddr; // latched user address
  reg [DW-1:0] uData; // latched user data
  // =====================================================
  // address of write cycle n for a sequence
  function [AW-1:0] seqAddr;
    input [2:0] o;
    input [2:0] n;
    input [AW-1:0] a;
    begin
      if (o == OP_WRITE || o == OP_RESET) begin
        seqAddr = a; // reset ignores address
      end else if (n == 3'h1) begin
        seqAddr = `FCSC_UNLOCK_ADDR2;
      end else begin
        seqAddr = `FCSC_UNLOCK_ADDR1;
      end
    end
  endfunction
  // data of write cycle n for a sequence
  function [DW-1:0] seqData;
    input [2:0] o;
    input [2:0] n;
    input [DW-1:0] d;
    begin
      case (n)
        3'h0: seqData = (o == OP_WRITE) ? d : (o == OP_RESET) ? `FCSC_CMD_RESET : `FCSC_UNLOCK_DATA1;
        3'h1: seqData = `FCSC_UNLOCK_DATA2;
        3'h2: seqData = (o == OP_AUTOSEL) ? `FCSC_CMD_AUTOSEL : (o == OP_ENTER) ? `FCSC_CMD_ENTER : `FCSC_CMD_EXIT1;
        default: seqData = `FCSC_CMD_EXIT2;
      endcase
    end
  endfunction
  // =====================================================
  // number of write cycles per operation
  function [2:0] opSteps;
    input [2:0] o;
    begin
      case (o)
        OP_AUTOSEL: opSteps = 3'h3;
        OP_ENTER: opSteps = 3'h3; // enter comes before any protect writes
        OP_EXIT: opSteps = 3'h4;
        OP_WRITE: opSteps = 3'h1;
        OP_RESET: opSteps = 3'h1;
        default: opSteps = 3'h0;
      endcase
    end
  endfunction
  // =====================================================
  // main sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= OP_READ;
      step <= 3'h0;
      nSteps <= 3'h0;
      cnt <= 4'h0;
      uAddr <= {AW{1'b0}};
      uData <= {DW{1'b0}};
      reqReady <= 1'b0;
      respValid <= 1'b0;
      respData <= {DW{1'b0}};
      inSecured <= 1'b0;
      inAutoselect <= 1'b0;
      flashAddr <= {AW{1'b0}};
      flashDqOut <= {DW{1'b0}};
      flashDqOe <= 1'b0;
      flashCe_n <= 1'b1; // strobes idle: no write can form
      flashWe_n <= 1'b1;
      flashOe_n <= 1'b1;
      flashReset_n <= 1'b1;
    end else begin
      respValid <= 1'b0;
      case (state)
        S_IDLE: begin
          flashCe_n <= 1'b1;
          flashWe_n <= 1'b1;
          flashOe_n <= 1'b1;
          flashDqOe <= 1'b0;
          reqReady <= 1'b1;
          // only take work while advertising ready, so no command starts mid-operation
          if (reqValid && reqReady) begin
            reqReady <= 1'b0;
            op <= reqOp;
            uData <= reqData;
            step <= 3'h0;
            nSteps <= opSteps(reqOp);
            cnt <= 4'h0;
            if (reqOp == OP_READID) begin
              // serial id placement by boot type
              uAddr <= (bottomBoot ? `FCSC_ID_BOTTOM : `FCSC_ID_TOP) | {{(AW-3){1'b0}}, reqAddr[2:0]};
            end else begin
              uAddr <= reqAddr;
            end
            if (reqOp == OP_HWRESET) begin
              flashReset_n <= 1'b0;
              state <= S_HWRST;
            end else if (opSteps(reqOp) == 3'h0) begin
              // plain reads pass the user address, a protect_group_address in autoselect
              flashAddr <= (reqOp == OP_READID) ? ((bottomBoot ? `FCSC_ID_BOTTOM : `FCSC_ID_TOP) |
                {{(AW-3){1'b0}}, reqAddr[2:0]}) : reqAddr;
              flashCe_n <= 1'b0;
              flashOe_n <= 1'b0;
              state <= S_RDWAIT;
            end else if (lockoutActive) begin
              // writes are pointless during lockout
              state <= S_DONE;
            end else begin
              state <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          // oe high, address, select low and strobe low, all set in this same cycle
          flashOe_n <= 1'b1;
          flashAddr <= seqAddr(op, step, uAddr);
          flashDqOut <= seqData(op, step, uData);
          flashDqOe <= 1'b1;
          flashCe_n <= 1'b0;
          flashWe_n <= 1'b0;
          cnt <= 4'h0;
          state <= S_PULSE;
        end
        S_PULSE: begin
          cnt <= cnt + 4'h1;
          if (cnt + 4'h1 >= `FCSC_TPULSE_CYC) begin
            // strobe rise latches data
            flashWe_n <= 1'b1;
            state <= S_RISE;
          end
        end
        S_RISE: begin
          flashCe_n <= 1'b1;
          flashDqOe <= 1'b0;
          if (step + 3'h1 >= nSteps) begin
            state <= S_DONE;
            // track device mode from completed sequence
            case (op)
              OP_AUTOSEL: inAutoselect <= 1'b1;
              OP_RESET: inAutoselect <= 1'b0;
              OP_ENTER: inSecured <= 1'b1;
              OP_EXIT: inSecured <= 1'b0;
              default: inAutoselect <= inAutoselect;
            endcase
          end else begin
            step <= step + 3'h1;
            state <= S_SETUP;
          end
        end
        S_RDWAIT: begin
          cnt <= cnt + 4'h1;
          if (cnt + 4'h1 >= `FCSC_TACC_CYC) begin
            respData <= flashDqIn;
            flashCe_n <= 1'b1;
            flashOe_n <= 1'b1;
            state <= S_DONE;
          end
        end
        S_HWRST: begin
          cnt <= cnt + 4'h1;
          if (cnt + 4'h1 >= `FCSC_TPULSE_CYC) begin
            // hardware reset leaves secured and autoselect modes
            flashReset_n <= 1'b1;
            inSecured <= 1'b0;
            inAutoselect <= 1'b0;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          respValid <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
      // device returns to read array and drops commands
      // placed last so it overrides a sequence that completes in the same cycle
      if (lockoutActive) begin
        inSecured <= 1'b0;
        inAutoselect <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/fcsc_host_props.sv
// assertions on the flash host ports
`timescale 1ns/1ps
`default_nettype none
module fcsc_host_props #(parameter AW = 21, parameter DW = 16) (
  input wire clk,
  input wire rst_n,
  input wire reqValid,
  input wire [2:0] reqOp,
  input wire reqReady,
  input wire respValid,
  input wire lockoutActive,
  input wire inSecured,
  input wire inAutoselect,
  input wire [AW-1:0] flashAddr,
  input wire [DW-1:0] flashDqOut,
  input wire flashDqOe,
  input wire flashCe_n,
  input wire flashWe_n,
  input wire flashOe_n
);
  // =====================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = reqValid && reqReady; // accepted request
  a_write_gate: assert property (!flashWe_n |-> !flashCe_n && flashOe_n) else $error("bad write strobes");
  a_bus_fight: assert property (flashDqOe |-> flashOe_n) else $error("data bus contention");
  a_addr_hold: assert property (!flashWe_n && $past(!flashWe_n) |-> $stable(flashAddr) && $stable(flashDqOut))
    else $error("address moved in pulse");
  a_read_lat: assert property (take && reqOp == 3'h0 |-> ##4 respValid) else $error("read late");
  a_resp_pulse: assert property (respValid |=> !respValid && reqReady) else $error("bad completion");
  a_lock_flags: assert property (lockoutActive |=> !inSecured && !inAutoselect) else $error("mode kept");
  a_auto_enter: assert property (take && reqOp == 3'h3 && !lockoutActive |-> ##14 respValid && inAutoselect)
    else $error("autoselect entry");
  a_lock_nowrite: assert property (take && lockoutActive && reqOp inside {[1:5]} |=> flashWe_n ##1 respValid)
    else $error("write strobe during lockout");
  a_exit_sec: assert property (take && reqOp == 3'h5 && !lockoutActive |-> ##[1:18] !inSecured)
    else $error("secured exit");
  a_enter_sec: assert property (take && reqOp == 3'h4 && !lockoutActive |-> ##[1:14] inSecured)
    else $error("secured entry");
endmodule
bind fcsc_host fcsc_host_props #(.AW(AW), .DW(DW)) fcsc_host_props_inst (.clk(clk), .rst_n(rst_n),
  .reqValid(reqValid), .reqOp(reqOp), .reqReady(reqReady), .respValid(respValid), .lockoutActive(lockoutActive),
  .inSecured(inSecured), .inAutoselect(inAutoselect), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
  .flashDqOe(flashDqOe), .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n));
`default_nettype wire

// File: test/fcsc_flash_model.sv
// behavioural flash command state model
`timescale 1ns/1ps
`default_nettype none
module fcsc_flash_model #(parameter logic [15:0] ID_CODE = 16'h0042) ( // code value arbitrary
  input wire logic [20:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic flashCe_n,
  input wire logic flashWe_n,
  input wire logic flashOe_n,
  input wire logic flashReset_n,
  input wire logic lockout,
  input wire logic bottomBoot,
  output logic [15:0] flashDqIn
);
  logic [1:0] cyc = 2'h0; // unlock step, read mode at power-up
  logic autosel = 1'b0; // autoselect mode
  logic secured = 1'b0; // secured sector mode
  logic [20:0] la = 21'h0; // latched write address
  logic [15:0] last = 16'h0; // last driven read value
  // secured mode maps the boot-end sector: 000000 in bottom boot, 1F8000 in top boot
  wire secHit = bottomBoot ? flashAddr[20:12] == 9'h000 : flashAddr[20:12] == 9'h1F8;
  // secured words are fixed contents that no write path alters
  wire [15:0] rd = autosel ? ID_CODE : (secured && secHit) ? {4'hC, flashAddr[11:0]} : flashAddr[15:0];
  // address taken on the later falling strobe, after pins settle
  always @(negedge flashWe_n or negedge flashCe_n) begin
    #1;
    if (!flashWe_n && !flashCe_n) la <= flashAddr;
  end
  // command decode on rising strobe
  always @(posedge flashWe_n or negedge flashReset_n or posedge lockout) begin
    if (!flashReset_n || lockout) begin
      cyc <= 2'h0;
      autosel <= 1'b0;
      secured <= 1'b0;
    end else if (!flashCe_n && flashOe_n) begin
      if (flashDqOut == 16'h00F0 && cyc != 2'h3) begin // address ignored
        cyc <= 2'h0;
        autosel <= 1'b0;
      end else begin
        cyc <= 2'h0; // bad step aborts
        if (cyc == 2'h0 && la == 21'h000555 && flashDqOut == 16'h00AA) cyc <= 2'h1;
        if (cyc == 2'h1 && la == 21'h0002AA && flashDqOut == 16'h0055) cyc <= 2'h2;
        if (cyc == 2'h2 && la == 21'h000555 && flashDqOut == 16'h0090) begin
          if (secured) cyc <= 2'h3;
          else autosel <= 1'b1;
        end
        if (cyc == 2'h2 && la == 21'h000555 && flashDqOut == 16'h0088) secured <= 1'b1;
        if (cyc == 2'h3 && flashDqOut == 16'h0000) secured <= 1'b0;
      end
    end
  end
  // released bus shows a changed value
  always @(posedge flashOe_n) last <= rd;
  assign flashDqIn = (!flashCe_n && !flashOe_n) ? rd : ~last;
endmodule
`default_nettype wire

// File: test/fcsc_host_tb.sv
// self-checking bench for the flash host
`timescale 1ns/1ps
`default_nettype none
module fcsc_host_tb;
  logic clk = 0, rst_n = 0, reqValid = 0, bottomBoot = 1, lockoutActive = 0;
  logic [2:0] reqOp = 0;
  logic [20:0] reqAddr = 0;
  logic [15:0] reqData = 0;
  wire reqReady, respValid, inSecured, inAutoselect, flashDqOe, flashCe_n, flashWe_n, flashOe_n, flashReset_n;
  wire [15:0] respData, flashDqOut, flashDqIn;
  wire [20:0] flashAddr;
  int n_mismatch = 0, checks = 0;
  fcsc_host fcsc_host_inst (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .bottomBoot(bottomBoot), .lockoutActive(lockoutActive), .flashDqIn(flashDqIn),
    .reqReady(reqReady), .respValid(respValid), .respData(respData), .inSecured(inSecured),
    .inAutoselect(inAutoselect), .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
    .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashReset_n(flashReset_n));
  fcsc_flash_model fcsc_flash_model_inst (.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashCe_n(flashCe_n),
    .flashWe_n(flashWe_n), .flashOe_n(flashOe_n), .flashReset_n(flashReset_n), .lockout(lockoutActive),
    .bottomBoot(bottomBoot), .flashDqIn(flashDqIn));
  initial forever #50 clk = ~clk;
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, s, e);
    end
  endtask
  // one request, wait for completion
  task op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (reqReady !== 1'b1) @(negedge clk);
    @(posedge clk) begin reqValid <= 1; reqOp <= o; reqAddr <= a; reqData <= d; end
    @(posedge clk) reqValid <= 0;
    do begin @(negedge clk); k++; end while (respValid !== 1'b1 && k < 100);
    if (k >= 100) chk(16'hDEAD, 16'h0000);
  endtask
  task t_power;
    chk({13'h0, flashCe_n, flashWe_n, flashReset_n}, 16'h0007);
    op(0, 21'h001234, 0); chk(respData, 16'h1234);
  endtask
  task t_autosel;
    op(3, 0, 0); chk(inAutoselect, 1);
    op(0, 21'h000000, 0); chk(respData, 16'h0042);
    op(0, 21'h000100, 0); chk(respData, 16'h0042);
    op(1, 21'h000123, 16'h00F0); op(0, 21'h000ABC, 0); chk(respData, 16'h0ABC);
    op(3, 0, 0); op(2, 0, 0); chk(inAutoselect, 0);
    op(1, 21'h000555, 16'h00AA); op(1, 21'h000123, 16'h0055); op(1, 21'h000555, 16'h0090);
    op(0, 21'h000077, 0); chk(respData, 16'h0077);
  endtask
  task t_secured(input logic bb);
    @(posedge clk) bottomBoot <= bb;
    op(4, 0, 0); chk(inSecured, 1);
    for (int i = 0; i < 8; i++) begin
      op(6, i, 0); chk(respData, {4'hC, 9'h0, i[2:0]});
    end
    op(1, bb ? 21'h000003 : 21'h1F8003, 16'h1234);
    op(6, 3, 0); chk(respData, 16'hC003);
    op(5, 0, 0); chk(inSecured, 0);
    op(6, 7, 0); chk(respData, bb ? 16'h0007 : 16'h8007);
  endtask
  task t_lockout;
    op(4, 0, 0);
    @(posedge clk) lockoutActive <= 1;
    op(3, 0, 0); chk({inSecured, inAutoselect}, 0);
    op(0, 21'h000005, 0); chk(respData, 16'h0005);
    @(posedge clk) lockoutActive <= 0;
  endtask
  task t_hwreset;
    op(4, 0, 0); op(7, 0, 0); chk(inSecured, 0);
    op(0, 21'h000009, 0); chk(respData, 16'h0009);
  endtask
  task end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    t_power();
    t_autosel();
    t_secured(0);
    t_secured(1);
    t_lockout();
    t_hwreset();
    end_of_test();
  end
endmodule
`default_nettype wire
